// >>> hdl/clock_gen_status_pkg.sv
package clock_gen_status_pkg;

    // ==================================================
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ==================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] STATUS_PRIMARY_OFF = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_SECONDARY_OFF = 12'h004;
    localparam logic [ADDR_W-1:0] CONTROL_OFF = 12'h008;

    // ==================================================
    // Primary status fields
    localparam int ACT_MODE_LSB = 6;
    localparam int REF_SRC_BIT = 5;
    localparam int LOCK_LOST_BIT = 4;
    localparam int LOCK_BIT = 3;
    localparam int CLOCK_LOST_BIT = 2;
    localparam int EXT_REF_BIT = 1;
    localparam int IRQ_FLAG_BIT = 0;

    // ==================================================
    // Secondary status fields
    localparam int OSC_STABLE_BIT = 0;

    // ==================================================
    // Control fields
    localparam int LOCK_RE_BIT = 7;
    localparam int MODE_SEL_LSB = 3;
    localparam int CLOCK_RE_BIT = 2;

    // ==================================================
    // Reset values and counts
    localparam logic [1:0] MODE_SEL_RST = 2'h0;
    localparam logic [1:0] STABLE_SAMPLES = 2'h2;

    // ==================================================
    // Clock modes
    typedef enum logic [1:0] {
        MODE_SELF = 2'h0,
        MODE_FLL_INT = 2'h1,
        MODE_BYPASS_EXT = 2'h2,
        MODE_FLL_EXT = 2'h3
    } clk_mode_t;

endpackage : clock_gen_status_pkg

// >>> hdl/clock_gen_status_flags.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module clock_gen_status_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clock_gen_status_pkg::ADDR_W-1:0] paddr,
    input wire logic [clock_gen_status_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [clock_gen_status_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gen_off,
    input wire logic fll_lock_raw,
    input wire logic ext_ref_ok_raw,
    input wire logic ref_osc_selected_raw,
    input wire logic clock_lost_event,
    input wire logic dco_static,
    input wire logic dco_sample,
    input wire logic dco_err_in_tol,
    output logic [1:0] mode_select,
    output logic [1:0] active_mode_report,
    output logic dco_monitor_en,
    output logic irq_request,
    output logic reset_request
);
    import clock_gen_status_pkg::*;

    // ==================================================
    // Bus decode
    logic setup_ph;
    logic access_ph;
    logic wr_done;
    logic rd_done;
    logic hit_pri;
    logic hit_sec;
    logic hit_ctl;
    logic mapped;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_pri = (paddr == STATUS_PRIMARY_OFF);
    assign hit_sec = (paddr == STATUS_SECONDARY_OFF);
    assign hit_ctl = (paddr == CONTROL_OFF);
    assign mapped = hit_pri || hit_sec || hit_ctl;
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign wr_done = access_ph && pwrite && mapped;
    assign rd_done = access_ph && !pwrite && mapped;

    // ==================================================
    // Control register
    logic lock_re_reg;
    logic clock_re_reg;
    logic [1:0] mode_sel_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_re_reg <= 1'b0;
            clock_re_reg <= 1'b0;
            mode_sel_reg <= MODE_SEL_RST;
        end else if (wr_done && hit_ctl && pstrb[0]) begin
            lock_re_reg <= pwdata[LOCK_RE_BIT];
            clock_re_reg <= pwdata[CLOCK_RE_BIT];
            mode_sel_reg <= pwdata[MODE_SEL_LSB +: 2];
        end
    end

    assign mode_select = mode_sel_reg;

    // ==================================================
    // Synchronisers
    logic [1:0] mode_s1_reg;
    logic [1:0] mode_s2_reg;
    logic lock_s1_reg;
    logic lock_s2_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ref_s1_reg;
    logic ref_s2_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_s1_reg <= MODE_SEL_RST;
            mode_s2_reg <= MODE_SEL_RST;
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
        end else begin
            mode_s1_reg <= mode_sel_reg;
            mode_s2_reg <= mode_s1_reg;
            lock_s1_reg <= fll_lock_raw;
            lock_s2_reg <= lock_s1_reg;
            ext_s1_reg <= ext_ref_ok_raw;
            ext_s2_reg <= ext_s1_reg;
            ref_s1_reg <= ref_osc_selected_raw;
            ref_s2_reg <= ref_s1_reg;
        end
    end

    // ==================================================
    // Oscillator stable detection
    logic osc_stable_flag;
    logic [1:0] good_cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            good_cnt_reg <= 2'h0;
            osc_stable_flag <= 1'b0;
        end else if (gen_off || dco_static) begin
            good_cnt_reg <= 2'h0;
            osc_stable_flag <= 1'b0;
        end else if (dco_sample) begin
            if (!dco_err_in_tol) begin
                good_cnt_reg <= 2'h0;
                osc_stable_flag <= 1'b0;
            end else if (good_cnt_reg == STABLE_SAMPLES - 2'h1) begin
                good_cnt_reg <= STABLE_SAMPLES;
                osc_stable_flag <= 1'b1;
            end else if (good_cnt_reg != STABLE_SAMPLES) begin
                good_cnt_reg <= good_cnt_reg + 2'h1;
            end
        end
    end

    // ==================================================
    // Active mode tracking
    clk_mode_t act_mode_reg;
    clk_mode_t act_mode_next;

    always_comb begin
        act_mode_next = clk_mode_t'(mode_s2_reg);
        if (mode_s2_reg[0] && !osc_stable_flag) begin
            act_mode_next = MODE_SELF;
        end
        if (mode_s2_reg == MODE_BYPASS_EXT && !ext_s2_reg) begin
            act_mode_next = MODE_SELF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_mode_reg <= MODE_SELF;
        end else if (!gen_off) begin
            act_mode_reg <= act_mode_next;
        end
    end

    assign active_mode_report = act_mode_reg;

    assign dco_monitor_en = !gen_off && (act_mode_reg == MODE_SELF) && osc_stable_flag;

    // ==================================================
    // Lock status and lock-lost detection
    logic engaged;
    logic lock_now;
    logic lock_prev_reg;
    logic engaged_prev_reg;
    logic lock_lost_ev;

    assign engaged = !gen_off && (act_mode_reg == MODE_FLL_INT || act_mode_reg == MODE_FLL_EXT);
    // Lock forced low when not engaged
    assign lock_now = engaged && lock_s2_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_prev_reg <= 1'b0;
            engaged_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= lock_now;
            engaged_prev_reg <= engaged;
        end
    end

    assign lock_lost_ev = engaged && engaged_prev_reg && lock_prev_reg && !lock_now;

    // ==================================================
    // Interrupt flag and clear sequence
    logic irq_flag_reg;
    logic clr_armed_reg;
    logic irq_event;
    logic irq_clear;

    // Lock event goes to interrupt when enable low
    // Clock event goes to interrupt when enable low
    assign irq_event = (lock_lost_ev && !lock_re_reg) || (clock_lost_event && !clock_re_reg);
    assign irq_clear = wr_done && hit_pri && pstrb[0] && pwdata[IRQ_FLAG_BIT] && clr_armed_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_armed_reg <= 1'b0;
        end else if (irq_event || irq_clear) begin
            clr_armed_reg <= 1'b0;
        end else if (rd_done && hit_pri && irq_flag_reg) begin
            clr_armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_reg <= 1'b0;
        end else if (irq_event) begin
            irq_flag_reg <= 1'b1;
        end else if (irq_clear) begin
            irq_flag_reg <= 1'b0;
        end
    end

    assign irq_request = irq_flag_reg;

    // ==================================================
    // Sticky loss flags
    logic lock_lost_sticky;
    logic clock_lost_sticky;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_lost_sticky <= 1'b0;
            clock_lost_sticky <= 1'b0;
        end else begin
            if (lock_lost_ev) begin
                lock_lost_sticky <= 1'b1;
            end else if (irq_clear) begin
                lock_lost_sticky <= 1'b0;
            end
            if (clock_lost_event) begin
                clock_lost_sticky <= 1'b1;
            end else if (irq_clear) begin
                clock_lost_sticky <= 1'b0;
            end
        end
    end

    assign reset_request = (lock_lost_sticky && lock_re_reg) ||
        (clock_lost_sticky && clock_re_reg);

    // ==================================================
    // Read data
    logic [7:0] pri_val;
    logic [7:0] sec_val;
    logic [DATA_W-1:0] rd_next;

    always_comb begin
        pri_val = 8'h00;
        pri_val[ACT_MODE_LSB +: 2] = act_mode_reg;
        pri_val[REF_SRC_BIT] = ref_s2_reg;
        pri_val[LOCK_LOST_BIT] = lock_lost_sticky;
        pri_val[LOCK_BIT] = lock_now;
        pri_val[CLOCK_LOST_BIT] = clock_lost_sticky;
        pri_val[EXT_REF_BIT] = ext_s2_reg;
        pri_val[IRQ_FLAG_BIT] = irq_flag_reg;
        sec_val = 8'h00;
        sec_val[OSC_STABLE_BIT] = osc_stable_flag;
        rd_next = '0;
        if (hit_pri) begin
            rd_next[7:0] = pri_val;
        end else if (hit_sec) begin
            rd_next[7:0] = sec_val;
        end else if (hit_ctl) begin
            rd_next[LOCK_RE_BIT] = lock_re_reg;
            rd_next[MODE_SEL_LSB +: 2] = mode_sel_reg;
            rd_next[CLOCK_RE_BIT] = clock_re_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_next;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mode_lag;
        $changed(mode_sel_reg) |=> ##1 (mode_s2_reg == $past(mode_sel_reg, 2));
    endproperty
    a_mode_lag: assert property (p_mode_lag) else $error("mode sync lag wrong");
    property p_lock_off;
        (gen_off || !act_mode_reg[0]) |-> !pri_val[LOCK_BIT];
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock shown outside FLL");
    property p_lock_sticky;
        lock_lost_ev |=> lock_lost_sticky ##1 (lock_lost_sticky || $past(irq_clear));
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock-lost not sticky");
    property p_clock_sticky;
        clock_lost_event |=> clock_lost_sticky;
    endproperty
    a_clock_sticky: assert property (p_clock_sticky) else $error("clock-lost not set");
    property p_reset_sel;
        (lock_lost_ev && lock_re_reg && !clock_lost_event && !irq_flag_reg && !wr_done)
            |=> reset_request && !irq_request;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("reset request missing");
    property p_irq_set;
        (clock_lost_event && !clock_re_reg) |=> irq_request;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt flag not set");
    property p_zero_write;
        (wr_done && hit_pri && !pwdata[IRQ_FLAG_BIT] && irq_flag_reg) |=> irq_flag_reg;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag");
    property p_no_arm_clear;
        (wr_done && hit_pri && !clr_armed_reg && irq_flag_reg) |=> irq_flag_reg;
    endproperty
    a_no_arm_clear: assert property (p_no_arm_clear) else $error("clear without read");
    property p_restart;
        irq_event |=> !clr_armed_reg && irq_flag_reg;
    endproperty
    a_restart: assert property (p_restart) else $error("sequence not restarted");
    property p_off_clears;
        gen_off |=> !osc_stable_flag;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("stable kept in off");
    property p_wait_stable;
        (!gen_off && mode_s2_reg[0] && !osc_stable_flag) |=> act_mode_reg == MODE_SELF;
    endproperty
    a_wait_stable: assert property (p_wait_stable) else $error("FLL entered early");

endmodule : clock_gen_status_flags

// >>> test/clock_gen_status_flags_bench.sv
`timescale 1ns/1ps

module clock_gen_status_flags_bench;
    import clock_gen_status_pkg::*;

    typedef struct {logic [7:0] d; logic e;} exp_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic gen_off, fll_lock_raw, ext_ref_ok_raw, ref_osc_selected_raw, clock_lost_event;
    logic dco_static, dco_sample, dco_err_in_tol, dco_monitor_en, irq_request, reset_request;
    logic [1:0] mode_select, active_mode_report, prev_mode;
    logic [1:0] modes [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    exp_t exp_q [$];
    int n_errors, cmp_count;
    logic [31:0] r;

    clock_gen_status_flags u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_off(gen_off), .fll_lock_raw(fll_lock_raw),
        .ext_ref_ok_raw(ext_ref_ok_raw), .ref_osc_selected_raw(ref_osc_selected_raw),
        .clock_lost_event(clock_lost_event), .dco_static(dco_static),
        .dco_sample(dco_sample), .dco_err_in_tol(dco_err_in_tol),
        .mode_select(mode_select), .active_mode_report(active_mode_report),
        .dco_monitor_en(dco_monitor_en), .irq_request(irq_request),
        .reset_request(reset_request)
    );

    // ==================================================
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Read monitor takes the oldest note at each completed read
    always @(posedge pclk) begin
        exp_t e;
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                check(prdata, {24'h0, e.d});
                check({31'h0, pslverr}, {31'h0, e.e});
            end
        end
    end

    // ==================================================
    // Bus and stimulus tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic e);
        exp_q.push_back('{d: d, e: e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic sample(input logic ok);
        dco_sample <= 1'b1;
        dco_err_in_tol <= ok;
        @(posedge pclk);
        dco_sample <= 1'b0;
        @(posedge pclk);
    endtask : sample

    task automatic lose_clock;
        clock_lost_event <= 1'b1;
        @(posedge pclk);
        clock_lost_event <= 1'b0;
        cyc(2);
    endtask : lose_clock

    // ==================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {presetn, gen_off, fll_lock_raw, ext_ref_ok_raw, ref_osc_selected_raw} = '0;
        {clock_lost_event, dco_static, dco_sample, dco_err_in_tol} = '0;
        n_errors = 0;
        cmp_count = 0;
        void'($urandom(7170));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(STATUS_PRIMARY_OFF, 8'h00, 1'b0);
        rd(STATUS_SECONDARY_OFF, 8'h00, 1'b0);
        rd(CONTROL_OFF, 8'h00, 1'b0);
        rd(12'h00c, 8'h00, 1'b1);
        apb(1'b1, STATUS_PRIMARY_OFF, 32'hfe);
        rd(STATUS_PRIMARY_OFF, 8'h00, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            ref_osc_selected_raw <= r[0];
            ext_ref_ok_raw <= r[1];
            cyc(3);
            rd(STATUS_PRIMARY_OFF, {2'h0, r[0], 3'h0, r[1], 1'b0}, 1'b0);
        end
        ref_osc_selected_raw <= 1'b0;
        ext_ref_ok_raw <= 1'b1;
        fll_lock_raw <= 1'b1;
        sample(1'b1);
        rd(STATUS_SECONDARY_OFF, 8'h00, 1'b0);
        check(dco_monitor_en, 1'b0);
        sample(1'b1);
        rd(STATUS_SECONDARY_OFF, 8'h01, 1'b0);
        sample(1'b0);
        rd(STATUS_SECONDARY_OFF, 8'h00, 1'b0);
        sample(1'b1);
        sample(1'b1);
        dco_static <= 1'b1;
        cyc(2);
        rd(STATUS_SECONDARY_OFF, 8'h00, 1'b0);
        dco_static <= 1'b0;
        sample(1'b1);
        sample(1'b1);
        rd(STATUS_PRIMARY_OFF, 8'h02, 1'b0);
        prev_mode = 2'h0;
        foreach (modes[i]) begin
            apb(1'b1, CONTROL_OFF, {27'h0, modes[i], 3'h0});
            @(negedge pclk);
            check(active_mode_report, prev_mode);
            check(mode_select, modes[i]);
            @(posedge pclk);
            cyc(4);
            rd(STATUS_PRIMARY_OFF, {modes[i], 2'h0, modes[i][0], 3'h2}, 1'b0);
            prev_mode = modes[i];
        end
        check(dco_monitor_en, 1'b1);
        apb(1'b1, CONTROL_OFF, 32'h08);
        cyc(5);
        gen_off <= 1'b1;
        cyc(3);
        rd(STATUS_SECONDARY_OFF, 8'h00, 1'b0);
        gen_off <= 1'b0;
        cyc(5);
        check(active_mode_report, 2'h0);
        sample(1'b1);
        sample(1'b1);
        cyc(3);
        check(active_mode_report, 2'h1);
        fll_lock_raw <= 1'b0;
        cyc(4);
        rd(STATUS_PRIMARY_OFF, 8'h53, 1'b0);
        check({irq_request, reset_request}, 2'b10);
        lose_clock();
        apb(1'b1, STATUS_PRIMARY_OFF, 32'h01);
        rd(STATUS_PRIMARY_OFF, 8'h57, 1'b0);
        apb(1'b1, STATUS_PRIMARY_OFF, 32'h00);
        rd(STATUS_PRIMARY_OFF, 8'h57, 1'b0);
        apb(1'b1, STATUS_PRIMARY_OFF, 32'h01);
        rd(STATUS_PRIMARY_OFF, 8'h42, 1'b0);
        check(irq_request, 1'b0);
        apb(1'b1, CONTROL_OFF, 32'h88);
        fll_lock_raw <= 1'b1;
        cyc(4);
        fll_lock_raw <= 1'b0;
        cyc(4);
        check({irq_request, reset_request}, 2'b01);
        rd(STATUS_PRIMARY_OFF, 8'h52, 1'b0);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(4);
        check(reset_request, 1'b0);
        rd(STATUS_PRIMARY_OFF, 8'h02, 1'b0);
        rd(STATUS_SECONDARY_OFF, 8'h00, 1'b0);
        apb(1'b1, CONTROL_OFF, 32'h04);
        lose_clock();
        check({irq_request, reset_request}, 2'b01);
        rd(STATUS_PRIMARY_OFF, 8'h06, 1'b0);
        apb(1'b1, CONTROL_OFF, 32'h00);
        lose_clock();
        check(irq_request, 1'b1);
        cyc(2);
        end_of_test();
    end

endmodule : clock_gen_status_flags_bench
